// File: src/afesc_defines.svh
`ifndef AFESC_DEFINES_SVH
`define AFESC_DEFINES_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define AFESC_ADDR_W          8
`define AFESC_REG_MODE        8'h00
`define AFESC_REG_REF         8'h04
`define AFESC_REG_OFFSET_R    8'h08
`define AFESC_REG_OFFSET_G    8'h0C
`define AFESC_REG_OFFSET_B    8'h10
`define AFESC_REG_GAIN_R      8'h14
`define AFESC_REG_GAIN_G      8'h18
`define AFESC_REG_GAIN_B      8'h1C
`define AFESC_REG_STATUS      8'h20

// ------------------------------------------------------------
// Mode register fields
// ------------------------------------------------------------
`define AFESC_MODE_SEL_LO     0
`define AFESC_MODE_SEL_HI     1
`define AFESC_MODE_COLOUR     2
`define AFESC_MODE_DSE        3
`define AFESC_MODE_CLAMP      4
`define AFESC_MODE_POS_LO     5
`define AFESC_MODE_POS_HI     6

// ------------------------------------------------------------
// Reference register fields
// ------------------------------------------------------------
`define AFESC_REF_CODE_LO     0
`define AFESC_REF_CODE_HI     3
`define AFESC_REF_RANGE       4
`define AFESC_REF_EXT         5

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define AFESC_MODE_RESET      8'h08
`define AFESC_REF_RESET       8'h00
`define AFESC_OFFSET_RESET    8'h80
`define AFESC_GAIN_RESET      8'h00
`define AFESC_NIBBLES         2'h3

`endif

// File: src/afesc_pkg.sv
package afesc_pkg;

   typedef enum logic [1:0] {
      AFESC_RED      = 2'h0,
      AFESC_GREEN    = 2'h1,
      AFESC_BLUE     = 2'h2,
      AFESC_RESERVED = 2'h3
   } afesc_colour_t;

   typedef enum logic [1:0] {
      AFESC_IDLE  = 2'h0,
      AFESC_WAIT  = 2'h1,
      AFESC_PULSE = 2'h3
   } afesc_state_t;

   typedef struct packed {
      logic [7:0] offset;
      logic [7:0] gain;
   } afesc_chan_t;

   typedef struct packed {
      logic [3:0] code;
      logic       range;
      logic       enable;
   } afesc_dac_t;

endpackage

// File: src/afesc_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "afesc_defines.svh"

// What this block does
// - Monochrome applies one fixed offset/gain set
// - Colour mode applies set chosen by select
// - Select codes red 00, green 01, blue 10
// - Clamp pulse derived from clock and strobe
// - Clamp enable captured on clock within strobe
// - Captured value gates next reset clamp
// - Clamp switch closed only while pulse high
// - Position field places clamp and reset sample
// - Clamping works in both sampling modes
// - Reference DAC driven by four-bit code
// - Range bit selects wide DAC range
// - External select disables internal DAC
// - Double sampling defaults on, uses reset
// - Reset reference used even without clamp
// - Off: reference sampled with video level
// - Twelve-bit word sent as three nibbles
// - Offsets, gains, mode bits are writable
module afesc_control (
   input  wire logic                       clk_in,
   input  wire logic                       rst_in,
   input  wire logic [`AFESC_ADDR_W-1:0]   addr_in,
   input  wire logic [7:0]                 wr_data_in,
   input  wire logic                       wr_in,
   input  wire logic                       rd_in,
   output var  logic [7:0]                 rd_data_out,
   input  wire logic                       mclk_in,
   input  wire logic                       sample_strobe_in,
   input  wire logic [11:0]                adc_data_in,
   input  wire logic                       adc_valid_in,
   output var  afesc_pkg::afesc_chan_t     chan_out,
   output var  afesc_pkg::afesc_colour_t   colour_applied_out,
   output var  afesc_pkg::afesc_dac_t      clamp_level_dac_out,
   output var  logic                       clamp_pulse_out,
   output var  logic                       reset_sample_out,
   output var  logic                       ref_sample_out,
   output var  logic                       video_sample_out,
   output var  logic                       double_sampling_out,
   output var  logic [3:0]                 nibble_out,
   output var  logic                       nibble_valid_out
);
   import afesc_pkg::*;

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   logic [7:0]    mode_reg;
   logic [7:0]    ref_reg;
   logic [7:0]    offset_reg [3];
   logic [7:0]    gain_reg [3];

   wire logic [1:0] colour_select         = mode_reg[`AFESC_MODE_SEL_HI:`AFESC_MODE_SEL_LO];
   wire logic       colour_mode           = mode_reg[`AFESC_MODE_COLOUR];
   wire logic       double_sampling_enable = mode_reg[`AFESC_MODE_DSE];
   wire logic       clamp_enable          = mode_reg[`AFESC_MODE_CLAMP];
   wire logic [1:0] reset_sample_position = mode_reg[`AFESC_MODE_POS_HI:`AFESC_MODE_POS_LO];
   wire logic [3:0] clamp_dac_code        = ref_reg[`AFESC_REF_CODE_HI:`AFESC_REF_CODE_LO];
   wire logic       clamp_dac_range       = ref_reg[`AFESC_REF_RANGE];
   wire logic       external_reference_select = ref_reg[`AFESC_REF_EXT];

   function automatic logic [2:0] colour_slot(input logic [`AFESC_ADDR_W-1:0] a,
                                              input logic [`AFESC_ADDR_W-1:0] base);
      logic [`AFESC_ADDR_W-1:0] d;
      d = a - base;
      colour_slot = (d == 8'h00) ? 3'h1 : (d == 8'h04) ? 3'h2 : (d == 8'h08) ? 3'h4 : 3'h0;
   endfunction

   wire logic [2:0] wr_offset_sel = wr_in ? colour_slot(addr_in, `AFESC_REG_OFFSET_R) : 3'h0;
   wire logic [2:0] wr_gain_sel   = wr_in ? colour_slot(addr_in, `AFESC_REG_GAIN_R) : 3'h0;
   wire logic       wr_mode       = wr_in && (addr_in == `AFESC_REG_MODE);
   wire logic       wr_ref        = wr_in && (addr_in == `AFESC_REG_REF);

   // Writes from the control port
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         mode_reg <= `AFESC_MODE_RESET;  // Double sampling on by default
         ref_reg  <= `AFESC_REF_RESET;
      end else begin
         if (wr_mode) begin
            mode_reg <= wr_data_in;  // One write retargets the colour
         end
         if (wr_ref) begin
            ref_reg <= wr_data_in;
         end
      end
   end

   for (genvar i = 0; i < 3; i++) begin : g_sets
      always_ff @(posedge clk_in) begin
         if (rst_in) begin
            offset_reg[i] <= `AFESC_OFFSET_RESET;
            gain_reg[i]   <= `AFESC_GAIN_RESET;
         end else begin
            if (wr_offset_sel[i]) begin
               offset_reg[i] <= wr_data_in;
            end
            if (wr_gain_sel[i]) begin
               gain_reg[i] <= wr_data_in;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Pin synchronisers and edges
   // ------------------------------------------------------------
   logic [2:0] mclk_sync;
   logic [2:0] strobe_sync;
   logic       strobe_clocked;
   logic       clamp_captured;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         mclk_sync   <= 3'h0;
         strobe_sync <= 3'h0;
      end else begin
         mclk_sync   <= {mclk_sync[1:0], mclk_in};
         strobe_sync <= {strobe_sync[1:0], sample_strobe_in};
      end
   end

   wire logic mclk_rise    = mclk_sync[1] && !mclk_sync[2];
   wire logic strobe_high  = strobe_sync[1];
   wire logic strobe_fall  = !strobe_sync[1] && strobe_sync[2];
   wire logic capture_edge = mclk_rise && strobe_high && !strobe_clocked;
   wire logic pixel_edge   = strobe_fall && strobe_clocked;

   // ------------------------------------------------------------
   // Clamp enable capture and colour set at pixel boundary
   // ------------------------------------------------------------
   wire afesc_colour_t next_colour =
      !colour_mode ? AFESC_RED :                                // Fixed set
      (colour_select == AFESC_RESERVED) ? colour_applied_out :  // Hold on reserved
      afesc_colour_t'(colour_select);
   wire logic [1:0] next_idx = next_colour;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         strobe_clocked     <= 1'b0;
         clamp_captured     <= 1'b0;
         colour_applied_out <= AFESC_RED;
         chan_out           <= '0;
      end else begin
         if (capture_edge) begin
            strobe_clocked <= 1'b1;
            clamp_captured <= clamp_enable;  // First clock edge within the strobe
         end else if (pixel_edge) begin
            strobe_clocked <= 1'b0;
         end
         if (pixel_edge) begin
            colour_applied_out <= next_colour;  // Whole set switches together
            chan_out.offset    <= offset_reg[next_idx];
            chan_out.gain      <= gain_reg[next_idx];
         end
      end
   end

   // ------------------------------------------------------------
   // Clamp and reset-sample timing
   // ------------------------------------------------------------
   afesc_state_t state;
   afesc_state_t next_state;
   logic [1:0]   edge_count;
   logic [1:0]   next_edge_count;

   always_comb begin
      next_state      = state;
      next_edge_count = edge_count;
      case (state)
         AFESC_IDLE: begin
            if (pixel_edge) begin
               next_state      = AFESC_WAIT;
               next_edge_count = reset_sample_position;
            end
         end
         AFESC_WAIT: begin
            if (mclk_rise) begin
               if (edge_count == 2'h0) begin
                  next_state = AFESC_PULSE;
               end else begin
                  next_edge_count = edge_count - 2'h1;
               end
            end
         end
         AFESC_PULSE: begin
            if (mclk_rise) begin
               next_state = AFESC_IDLE;
            end
         end
         default: begin
            next_state = AFESC_IDLE;
         end
      endcase
   end

   wire logic next_pulse = (next_state == AFESC_PULSE);

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state            <= AFESC_IDLE;
         edge_count       <= 2'h0;
         clamp_pulse_out  <= 1'b0;
         reset_sample_out <= 1'b0;
         ref_sample_out   <= 1'b0;
         video_sample_out <= 1'b0;
      end else begin
         state            <= next_state;
         edge_count       <= next_edge_count;
         // Pulse in either sampling mode; drives the clamp switch directly
         clamp_pulse_out  <= next_pulse && clamp_captured;
         // Reset level sampled every pixel, clamped or not
         reset_sample_out <= next_pulse;
         video_sample_out <= capture_edge;
         // Reference instant: reset level or, with double sampling off, the video instant
         ref_sample_out   <= double_sampling_enable ? next_pulse : capture_edge;
      end
   end

   // ------------------------------------------------------------
   // Reference DAC and sampling selection
   // ------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         clamp_level_dac_out <= '0;
         double_sampling_out <= 1'b1;
      end else begin
         clamp_level_dac_out.code   <= clamp_dac_code;
         clamp_level_dac_out.range  <= clamp_dac_range;
         clamp_level_dac_out.enable <= !external_reference_select;
         double_sampling_out        <= double_sampling_enable;
      end
   end

   // ------------------------------------------------------------
   // Output word serialiser
   // ------------------------------------------------------------
   logic [11:0] out_word;
   logic [1:0]  nibbles_left;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         out_word         <= 12'h000;
         nibbles_left     <= 2'h0;
         nibble_out       <= 4'h0;
         nibble_valid_out <= 1'b0;
      end else if (adc_valid_in) begin
         out_word         <= {adc_data_in[7:0], 4'h0};  // Most significant nibble first
         nibbles_left     <= `AFESC_NIBBLES - 2'h1;
         nibble_out       <= adc_data_in[11:8];
         nibble_valid_out <= 1'b1;
      end else if (nibbles_left != 2'h0) begin
         out_word         <= {out_word[7:0], 4'h0};
         nibbles_left     <= nibbles_left - 2'h1;
         nibble_out       <= out_word[11:8];
         nibble_valid_out <= 1'b1;
      end else begin
         nibble_valid_out <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------
   wire logic [7:0] status_word = {2'h0, state == AFESC_PULSE, clamp_captured,
                                   strobe_clocked, 1'b0, colour_applied_out};
   wire logic [2:0] rd_offset_sel = colour_slot(addr_in, `AFESC_REG_OFFSET_R);
   wire logic [2:0] rd_gain_sel   = colour_slot(addr_in, `AFESC_REG_GAIN_R);
   wire logic [7:0] rd_mux =
      (addr_in == `AFESC_REG_MODE)   ? mode_reg :
      (addr_in == `AFESC_REG_REF)    ? ref_reg :
      (addr_in == `AFESC_REG_STATUS) ? status_word :
      rd_offset_sel[0] ? offset_reg[0] : rd_offset_sel[1] ? offset_reg[1] :
      rd_offset_sel[2] ? offset_reg[2] : rd_gain_sel[0] ? gain_reg[0] :
      rd_gain_sel[1] ? gain_reg[1] : rd_gain_sel[2] ? gain_reg[2] : 8'h00;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rd_data_out <= 8'h00;
      end else begin
         rd_data_out <= rd_in ? rd_mux : 8'h00;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_mono_set;
      @(posedge clk_in) disable iff (rst_in)
      pixel_edge && !colour_mode |=> colour_applied_out == AFESC_RED && chan_out.gain == $past(gain_reg[0]);
   endproperty
   a_mono_set: assert property (p_mono_set) else $error("mono set not applied");

   property p_colour_set;
      @(posedge clk_in) disable iff (rst_in)
      pixel_edge && colour_mode && colour_select != 2'h3 |=> colour_applied_out == $past(colour_select);
   endproperty
   a_colour_set: assert property (p_colour_set) else $error("colour set mismatch");

   property p_capture;
      @(posedge clk_in) disable iff (rst_in)
      capture_edge |=> clamp_captured == $past(clamp_enable) && strobe_clocked;
   endproperty
   a_capture: assert property (p_capture) else $error("clamp enable not captured");

   property p_clamp_gate;
      @(posedge clk_in) disable iff (rst_in)
      clamp_pulse_out |-> reset_sample_out && clamp_captured;
   endproperty
   a_clamp_gate: assert property (p_clamp_gate) else $error("clamp without captured enable");

   property p_pulse_len;
      @(posedge clk_in) disable iff (rst_in)
      $rose(reset_sample_out) |-> reset_sample_out[*2];
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("reset sample too short");

   property p_ref_instant;
      @(posedge clk_in) disable iff (rst_in)
      ref_sample_out && !$past(double_sampling_enable) |-> video_sample_out;
   endproperty
   a_ref_instant: assert property (p_ref_instant) else $error("reference not with video");

   property p_dac;
      @(posedge clk_in) disable iff (rst_in)
      wr_ref |=> ##1 clamp_level_dac_out.enable == !$past(wr_data_in[`AFESC_REF_EXT], 2);
   endproperty
   a_dac: assert property (p_dac) else $error("reference DAC enable wrong");

   property p_nibbles;
      @(posedge clk_in) disable iff (rst_in)
      adc_valid_in ##1 !adc_valid_in [*2] |-> nibble_valid_out && $past(nibble_valid_out);
   endproperty
   a_nibbles: assert property (p_nibbles) else $error("nibble stream broken");

endmodule // afesc_control

`default_nettype wire

// File: test/afesc_scan_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Scanner timing controller: master clock and sample strobe
// ------------------------------------------------------------
module afesc_scan_model (
   output var logic mclk_out,
   output var logic strobe_out
);
   initial begin
      mclk_out = 1'b0;
      strobe_out = 1'b0;
   end

   // Clock stands still between pixels; half period sets prompt or slow pacing
   task automatic pixel(input int half_ns);
      #1;                                // Step off the bench clock edge
      strobe_out = 1'b1;
      #(half_ns) mclk_out = 1'b1;
      #(half_ns) mclk_out = 1'b0;
      strobe_out = 1'b0;
      repeat (5) begin
         #(half_ns) mclk_out = 1'b1;
         #(half_ns) mclk_out = 1'b0;
      end
      #(half_ns);
   endtask
endmodule // afesc_scan_model

`default_nettype wire

// File: test/afe_sampling_clamp_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "afesc_defines.svh"

module afe_sampling_clamp_control_bench;
   import afesc_pkg::*;
   logic           clk_in = 1'b0;
   logic           rst_in = 1'b1;
   logic [7:0]     addr_in = 8'h00;
   logic [7:0]     wr_data_in = 8'h00;
   logic           wr_in = 1'b0;
   logic           rd_in = 1'b0;
   logic [11:0]    adc_data_in = 12'h000;
   logic           adc_valid_in = 1'b0;
   wire logic      mclk;
   wire logic      strobe;
   logic [7:0]     rd_data_out;
   afesc_chan_t    chan_out;
   afesc_colour_t  colour_applied_out;
   afesc_dac_t     clamp_level_dac_out;
   logic           clamp_pulse_out, reset_sample_out, ref_sample_out, video_sample_out;
   logic           double_sampling_out, nibble_valid_out;
   logic [3:0]     nibble_out;
   int             num_errors = 0, n_tests = 0, seed = 32'h1544;
   int             rise_cnt = 0, rs_rises, rs_cycles, clamp_cycles, ref_hits, vid_cnt;
   logic           rs_prev = 1'b0;
   int             off[3], gn[3];
   logic [7:0]     r, v;
   logic [11:0]    w;
   logic [7:0]     m;
   int             nib_q[$];

   always #2.5 clk_in = ~clk_in;

   afesc_scan_model afesc_scan_model_inst (.mclk_out(mclk), .strobe_out(strobe));

   afesc_control afesc_control_inst (
      .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
      .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .mclk_in(mclk),
      .sample_strobe_in(strobe), .adc_data_in(adc_data_in), .adc_valid_in(adc_valid_in),
      .chan_out(chan_out), .colour_applied_out(colour_applied_out),
      .clamp_level_dac_out(clamp_level_dac_out), .clamp_pulse_out(clamp_pulse_out),
      .reset_sample_out(reset_sample_out), .ref_sample_out(ref_sample_out),
      .video_sample_out(video_sample_out), .double_sampling_out(double_sampling_out),
      .nibble_out(nibble_out), .nibble_valid_out(nibble_valid_out)
   );

   // ------------------------------------------------------------
   // Pixel watchers: mclk rises since boundary, pulse widths
   // ------------------------------------------------------------
   always @(posedge mclk) rise_cnt++;
   always @(negedge strobe) rise_cnt = 0;
   always @(posedge clk_in) begin
      if (reset_sample_out === 1'b1 && rs_prev !== 1'b1) rs_rises = rise_cnt;
      if (reset_sample_out === 1'b1) rs_cycles++;
      if (clamp_pulse_out === 1'b1) clamp_cycles++;
      if (reset_sample_out === 1'b1 && ref_sample_out === 1'b1) ref_hits++;
      if (video_sample_out === 1'b1) vid_cnt++;
      rs_prev = reset_sample_out;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wr_data_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 d = rd_data_out;
   endtask

   task automatic run_pixel(input int half_ns);
      rs_rises = -1;
      rs_cycles = 0;
      clamp_cycles = 0;
      ref_hits = 0;
      vid_cnt = 0;
      afesc_scan_model_inst.pixel(half_ns);
      repeat (4) @(posedge clk_in);
   endtask

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      #200000;
      num_errors++;
      report_and_stop();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      chk(double_sampling_out, 16'h0001);
      for (int i = 0; i < 8; i++) begin
         rd(8'(i * 4), r);
         chk(r, (i == 0) ? 8'h08 : (i == 1) ? 8'h00 : (i < 5) ? 8'h80 : 8'h00);
      end
      rd(8'h24, r);
      chk(r, 16'h0000);
      for (int i = 2; i < 8; i++) begin
         v = 8'($random(seed));
         if (i < 5) off[i-2] = v;
         else gn[i-5] = v;
         wr(8'(i * 4), v);
         rd(8'(i * 4), r);
         chk(r, v);
      end
      $display("registers done");
      for (int s = 0; s < 3; s++) begin
         wr(`AFESC_REG_MODE, 8'h0C | 8'(s));
         repeat (4) @(posedge clk_in);
         if (s > 0) chk(colour_applied_out, 16'(s - 1));
         run_pixel(40);
         chk(chan_out, {8'(off[s]), 8'(gn[s])});
         chk(colour_applied_out, 16'(s));
      end
      wr(`AFESC_REG_MODE, 8'h0F);
      run_pixel(40);
      chk(colour_applied_out, 16'h0002);
      wr(`AFESC_REG_MODE, 8'h0A);
      run_pixel(100);
      chk(chan_out, {8'(off[0]), 8'(gn[0])});
      $display("colour done");
      for (int k = 0; k < 4; k++) begin
         v = {2'h0, 2'(k), 4'($random(seed))};
         wr(`AFESC_REG_REF, v);
         rd(`AFESC_REG_REF, r);
         chk(r, v);
         chk(clamp_level_dac_out, {v[3:0], v[4], ~v[5]});
      end
      $display("reference dac done");
      for (int d = 0; d < 2; d++)
         for (int p = 0; p < 4; p++)
            for (int e = 0; e < 2; e++) begin
               m = {1'b0, 2'(p), 1'(e), 1'(d), 3'h4};
               wr(`AFESC_REG_MODE, m);
               run_pixel(e ? 40 : 100);
               chk(16'(rs_rises), 16'(p + 1));
               chk(16'(clamp_cycles), e ? 16'(rs_cycles) : 16'h0000);
               chk(ref_hits > 0, 16'(d));
               chk(double_sampling_out, 16'(d));
               chk(16'(vid_cnt), 16'h0001);
            end
      $display("clamp timing done");
      rd(`AFESC_REG_STATUS, r);
      chk(r, 16'h0010);
      for (int k = 0; k < 4; k++) begin
         w = 12'($random(seed));
         for (int n = 0; n < 3; n++) begin
            nib_q.push_back(int'(w[11-4*n -: 4]));  // Model: most significant nibble first
         end
         @(posedge clk_in);
         adc_data_in <= w;
         adc_valid_in <= 1'b1;
         @(posedge clk_in);
         adc_valid_in <= 1'b0;
         for (int n = 0; n < 3; n++) begin
            #1 chk({nibble_valid_out, nibble_out}, {1'b1, 4'(nib_q.pop_front())});
            @(posedge clk_in);
         end
         #1 chk(nibble_valid_out, 16'h0000);
      end
      $display("output word done");
      report_and_stop();
   end
endmodule // afe_sampling_clamp_control_bench

`default_nettype wire
